// *** src/jrd_decode.sv ***
`timescale 1ns/1ns
// Operation
// - top bits 110 select indexed jump, 111 select pc-relative jump
// - jump-with-transfer always tests its condition, never defaulted true
// - indexed target is index plus modify; index register left unchanged
// - direction bit picks read into or write from the named register
// - transfer addressed by data index, then index updated by data modify
// - compute runs beside the transfer; an empty compute is a no-op
// - relative target is pc plus sign-extended 6-bit offset
// - taken return branches to top of pc stack
// - subroutine return pops pc stack only
// - interrupt return also pops status stack when status was pushed
// - interrupt return clears serviced bit in latch and mask pointer
// - return taken when condition true or no condition encoded
// - plain compute runs with return; else compute only when condition false
// - subroutine return takes delay and reentry; interrupt return delay only
// - loop count drops two before end; reentry return blocks second drop
// - dual-element return needs condition true in both elements
// - in dual mode each element decides its own compute
// - secondary element computes on the complementary registers
// - true condition jumps; false condition does transfer and compute
// - secondary transfer uses primary address plus one, only if its test fails
module jrd_decode
    import jrd_pkg::*;
#(
    parameter int ADDR_W = AW
)(
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                instr_valid,
    input  wire logic [47:0]         instr,
    input  wire logic [ADDR_W-1:0]   pc,
    input  wire logic                simd_mode,
    input  wire logic [NFLAG-1:0]    flags_x,
    input  wire logic [NFLAG-1:0]    flags_y,
    input  wire logic [ADDR_W-1:0]   pc_stack_top,
    input  wire logic                status_pushed,
    input  wire logic [4:0]          serviced_irq,
    input  wire logic                loop_dec_point,
    input  wire logic                dag_wr_en,
    input  wire logic [4:0]          dag_wr_sel,
    input  wire logic [ADDR_W-1:0]   dag_wr_data,
    output logic                     branch_taken_r,
    output logic [ADDR_W-1:0]        branch_target_r,
    output logic                     branch_delayed_r,
    output logic                     pc_stack_pop_r,
    output logic                     status_stack_pop_r,
    output logic [NIRQ-1:0]          latch_clear_r,
    output logic [NIRQ-1:0]          mask_ptr_clear_r,
    output logic                     loop_count_dec_r,
    output jrd_dm_req_s              dm_req_r,
    output jrd_comp_req_s            comp_req_r
);
    // address arithmetic wraps at the address width
    function automatic logic [ADDR_W-1:0] addr_add(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        logic [ADDR_W:0] sum;
        sum      = {1'b0, a} + {1'b0, b};
        addr_add = sum[ADDR_W-1:0];
    endfunction : addr_add

    function automatic logic [NIRQ-1:0] irq_bit(input logic [4:0] idx);
        irq_bit      = '0;
        irq_bit[idx] = 1'b1;
    endfunction : irq_bit

    // index and modify registers of both address generators
    logic [ADDR_W-1:0] data_idx  [NREG];
    logic [ADDR_W-1:0] data_mod  [NREG];
    logic [ADDR_W-1:0] jump_idx  [NREG];
    logic [ADDR_W-1:0] jump_mod  [NREG];

    logic              lr_pending_r;
    logic              ok_x;
    logic              ok_y;
    logic              is_jump;
    logic              is_ret;
    logic              is_rti;
    logic              both_ok;
    logic              jump_go;
    logic              ret_go;
    logic              xfer_x;
    logic              xfer_y;
    logic              has_comp;
    logic              use_else;
    logic              lr_mod;
    logic              comp_x;
    logic              comp_y;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] rel_ext;
    logic [2:0]        didx_sel;
    logic [2:0]        dmod_sel;

    // per-element condition tests; jump format has no default-true code
    jrd_test_selector_eval u_test_selector_x (
        .test_selector (instr[TEST_SELECTOR_HI:TEST_SELECTOR_LO]),
        .flags         (flags_x),
        .allow_default (is_ret),
        .test_selector_true     (ok_x)
    );

    jrd_test_selector_eval u_test_selector_y (
        .test_selector (instr[TEST_SELECTOR_HI:TEST_SELECTOR_LO]),
        .flags         (flags_y),
        .allow_default (is_ret),
        .test_selector_true     (ok_y)
    );

    // format decode
    always_comb begin
        is_jump  = instr_valid && (instr[OPC_HI:OPC_LO] == OPC_JUMP_INDIRECT ||
                                   instr[OPC_HI:OPC_LO] == OPC_JUMP_RELATIVE);
        is_ret   = instr_valid && instr[OPC_HI:OPC_LO] == OPC_GROUP_ZERO &&
                   (instr[SUBOP_HI:SUBOP_LO] == SUBOP_RET_SUB || instr[SUBOP_HI:SUBOP_LO] == SUBOP_RET_INT);
        is_rti   = is_ret && instr[SUBOP_HI:SUBOP_LO] == SUBOP_RET_INT;
        didx_sel = instr[DIDX_HI:DIDX_LO];
        dmod_sel = instr[DMOD_HI:DMOD_LO];
        has_comp = |instr[COMP_HI:COMP_LO];
        use_else = instr[ELSE_POS];
        lr_mod   = is_ret && !is_rti && instr[LR_POS];
    end

    // branch decision: dual mode ands the two element tests
    always_comb begin
        both_ok = simd_mode ? (ok_x && ok_y) : ok_x;
        jump_go = is_jump && both_ok;
        ret_go  = is_ret && both_ok;
        xfer_x  = is_jump && !ok_x;
        xfer_y  = is_jump && simd_mode && !ok_y;
    end

    // per-element compute enables
    always_comb begin
        if (is_jump) begin
            comp_x = has_comp && !ok_x;
            comp_y = has_comp && simd_mode && !ok_y;
        end else if (is_ret) begin
            comp_x = has_comp && (use_else ? !ok_x : ok_x);
            comp_y = has_comp && simd_mode && (use_else ? !ok_y : ok_y);
        end else begin
            comp_x = 1'b0;
            comp_y = 1'b0;
        end
    end

    // branch target selection
    always_comb begin
        rel_ext = {{(ADDR_W-RELADDR_W){instr[REL_HI]}}, instr[REL_HI:REL_LO]};
        if (is_ret) begin
            target = pc_stack_top;
        end else if (instr[OPC_HI:OPC_LO] == OPC_JUMP_INDIRECT) begin
            target = addr_add(jump_idx[instr[JIDX_HI:JIDX_LO]],
                              jump_mod[instr[JMOD_HI:JMOD_LO]]);
        end else begin
            target = addr_add(pc, rel_ext);
        end
    end

    // sequencer outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            branch_taken_r   <= 1'b0;
            branch_target_r  <= '0;
            branch_delayed_r <= 1'b0;
        end else begin
            branch_taken_r   <= jump_go || ret_go;
            branch_target_r  <= (jump_go || ret_go) ? target : branch_target_r;
            // jump format never delays; return delays on its modifier
            branch_delayed_r <= ret_go && instr[DELAY_POS];
        end
    end

    // stack and interrupt bookkeeping on a taken return
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_stack_pop_r     <= 1'b0;
            status_stack_pop_r <= 1'b0;
            latch_clear_r      <= '0;
            mask_ptr_clear_r   <= '0;
        end else begin
            pc_stack_pop_r     <= ret_go;
            status_stack_pop_r <= ret_go && is_rti && status_pushed;
            latch_clear_r      <= (ret_go && is_rti) ? irq_bit(serviced_irq) : '0;
            mask_ptr_clear_r   <= (ret_go && is_rti) ? irq_bit(serviced_irq) : '0;
        end
    end

    // a reentry return arms suppression of the next decrement point;
    // an arm in the same cycle as a consume keeps the arm
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lr_pending_r     <= 1'b0;
            loop_count_dec_r <= 1'b0;
        end else begin
            loop_count_dec_r <= loop_dec_point && !lr_pending_r;
            if (ret_go && lr_mod) begin
                lr_pending_r <= 1'b1;
            end else if (loop_dec_point) begin
                lr_pending_r <= 1'b0;
            end
        end
    end

    // data memory request for elements whose test failed
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dm_req_r <= '0;
        end else begin
            dm_req_r.valid_x <= xfer_x;
            dm_req_r.valid_y <= xfer_y;
            dm_req_r.write   <= is_jump && instr[DIR_POS];
            dm_req_r.reg_sel <= instr[DREG_HI:DREG_LO];
            dm_req_r.addr_x  <= data_idx[didx_sel];
            dm_req_r.addr_y  <= addr_add(data_idx[didx_sel], ADDR_W'(1));
        end
    end

    // compute dispatch; secondary names the complementary registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_req_r <= '0;
        end else begin
            comp_req_r.en_x         <= comp_x;
            comp_req_r.en_y         <= comp_y;
            comp_req_r.complement_y <= simd_mode;
            comp_req_r.op           <= (comp_x || comp_y) ? instr[COMP_HI:COMP_LO] : '0;
        end
    end

    // data index post-modify beats a same-cycle software load, so the
    // address stream stays consistent; jump index is never written back
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NREG; i++) begin
                data_idx[i] <= REG_RESET;
                data_mod[i] <= REG_RESET;
                jump_idx[i] <= REG_RESET;
                jump_mod[i] <= REG_RESET;
            end
        end else begin
            if (dag_wr_en) begin
                unique case (dag_wr_sel[4:3])
                    BANK_DATA_IDX: data_idx[dag_wr_sel[2:0]] <= dag_wr_data;
                    BANK_DATA_MOD: data_mod[dag_wr_sel[2:0]] <= dag_wr_data;
                    BANK_JUMP_IDX: jump_idx[dag_wr_sel[2:0]] <= dag_wr_data;
                    BANK_JUMP_MOD: jump_mod[dag_wr_sel[2:0]] <= dag_wr_data;
                endcase
            end
            if (xfer_x || xfer_y) begin
                data_idx[didx_sel] <= addr_add(data_idx[didx_sel], data_mod[dmod_sel]);
            end
        end
    end

    // checks
    AST_JUMP_TRUE_NO_XFER: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_jump && both_ok && !simd_mode) |=> (branch_taken_r && !dm_req_r.valid_x && !comp_req_r.en_x))
        else $error("true jump condition must branch without transfer");

    AST_JUMP_FALSE_XFER: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_jump && !ok_x) |=> (dm_req_r.valid_x && !branch_taken_r))
        else $error("false jump condition must transfer and not branch");

    AST_NO_DEFAULT_TRUE: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_jump && instr[TEST_SELECTOR_HI:TEST_SELECTOR_LO] == TEST_SELECTOR_ALWAYS && !flags_x[TEST_SELECTOR_ALWAYS] && !simd_mode)
        |=> !branch_taken_r)
        else $error("jump condition was defaulted to true");

    AST_INDEXED_TARGET: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (jump_go && instr[OPC_HI:OPC_LO] == OPC_JUMP_INDIRECT)
        |=> (branch_target_r == $past(addr_add(jump_idx[instr[JIDX_HI:JIDX_LO]], jump_mod[instr[JMOD_HI:JMOD_LO]]))))
        else $error("indexed jump target is not index plus modify");

    AST_REL_TARGET: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (jump_go && instr[OPC_HI:OPC_LO] == OPC_JUMP_RELATIVE)
        |=> (branch_target_r == addr_add($past(pc), $past(rel_ext))))
        else $error("relative jump target wrong");

    AST_POSTMODIFY: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (xfer_x && !dag_wr_en)
        |=> (data_idx[$past(didx_sel)] == addr_add(dm_req_r.addr_x, $past(data_mod[dmod_sel]))))
        else $error("data index not post-modified after transfer");

    AST_Y_ADDR: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        dm_req_r.valid_y |-> (dm_req_r.addr_y == addr_add(dm_req_r.addr_x, ADDR_W'(1))))
        else $error("secondary address is not primary plus one");

    AST_RTS_POP_ONLY: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (ret_go && !is_rti) |=> (pc_stack_pop_r && !status_stack_pop_r && latch_clear_r == '0))
        else $error("subroutine return touched status or interrupt state");

    AST_RTI_CLEAR: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (ret_go && is_rti) |=> (latch_clear_r == irq_bit($past(serviced_irq)) &&
                                mask_ptr_clear_r == latch_clear_r && status_stack_pop_r == $past(status_pushed)))
        else $error("interrupt return clear or status pop wrong");

    AST_SIMD_AND: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_ret && simd_mode && (ok_x != ok_y)) |=> (!branch_taken_r && !pc_stack_pop_r))
        else $error("dual return taken with one element false");

    AST_LR_SUPPRESS: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (ret_go && lr_mod) ##1 (loop_dec_point && !(ret_go && lr_mod)) |=> !loop_count_dec_r)
        else $error("reentry return did not suppress loop decrement");

    AST_RET_DELAY: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        ret_go |=> (branch_delayed_r == $past(instr[DELAY_POS])))
        else $error("return delay does not follow its modifier");

    AST_Y_PASS_NO_XFER: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_jump && simd_mode && ok_y) |=> !dm_req_r.valid_y)
        else $error("secondary transferred although its test passed");

    AST_SIMD_COMP: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_ret && simd_mode && has_comp && !use_else) |=> (comp_req_r.en_y == $past(ok_y)))
        else $error("secondary compute does not follow its own test");

    AST_COMPLEMENT_Y: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        comp_req_r.en_y |-> comp_req_r.complement_y)
        else $error("secondary compute without complementary registers");

    AST_UNKNOWN_QUIET: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        !(is_jump || is_ret) |=> (!branch_taken_r && !pc_stack_pop_r && !dm_req_r.valid_x && !comp_req_r.en_x))
        else $error("unrecognised word produced activity");

    AST_EMPTY_COMP: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        (is_jump && !ok_x && !has_comp) |=> !comp_req_r.en_x)
        else $error("empty compute field was dispatched");
endmodule : jrd_decode

// *** src/jrd_pkg.sv ***
package jrd_pkg;
    // widths
    localparam int AW            = 24;
    localparam int NREG          = 8;
    localparam int NIRQ          = 32;
    localparam int NFLAG         = 32;
    // opcode fields
    localparam int OPC_HI        = 47;
    localparam int OPC_LO        = 45;
    localparam int SUBOP_HI      = 44;
    localparam int SUBOP_LO      = 40;
    localparam int DIR_POS       = 44;
    localparam int DIDX_HI       = 43;
    localparam int DIDX_LO       = 41;
    localparam int DMOD_HI       = 40;
    localparam int DMOD_LO       = 38;
    localparam int TEST_SELECTOR_HI       = 37;
    localparam int TEST_SELECTOR_LO       = 33;
    localparam int JIDX_HI       = 32;
    localparam int JIDX_LO       = 30;
    localparam int JMOD_HI       = 29;
    localparam int JMOD_LO       = 27;
    localparam int REL_HI        = 32;
    localparam int REL_LO        = 27;
    localparam int RELADDR_W     = 6;
    localparam int DREG_HI       = 26;
    localparam int DREG_LO       = 23;
    localparam int DELAY_POS     = 26;
    localparam int ELSE_POS      = 25;
    localparam int LR_POS        = 24;
    localparam int COMP_HI       = 22;
    localparam int COMP_LO       = 0;
    localparam int COMP_W        = 23;
    // encodings
    localparam logic [2:0] OPC_JUMP_INDIRECT = 3'h6;
    localparam logic [2:0] OPC_JUMP_RELATIVE = 3'h7;
    localparam logic [2:0] OPC_GROUP_ZERO    = 3'h0;
    localparam logic [4:0] SUBOP_RET_SUB     = 5'h0a;
    localparam logic [4:0] SUBOP_RET_INT     = 5'h0b;
    localparam logic [4:0] TEST_SELECTOR_ALWAYS       = 5'h1f;
    // dag write select: upper two bits pick the bank
    localparam logic [1:0] BANK_DATA_IDX     = 2'h0;
    localparam logic [1:0] BANK_DATA_MOD     = 2'h1;
    localparam logic [1:0] BANK_JUMP_IDX     = 2'h2;
    localparam logic [1:0] BANK_JUMP_MOD     = 2'h3;
    localparam logic [AW-1:0] REG_RESET      = 24'h000000;

    typedef struct packed {
        logic          valid_x;
        logic          valid_y;
        logic          write;
        logic [3:0]    reg_sel;
        logic [AW-1:0] addr_x;
        logic [AW-1:0] addr_y;
    } jrd_dm_req_s;

    typedef struct packed {
        logic              en_x;
        logic              en_y;
        logic              complement_y;
        logic [COMP_W-1:0] op;
    } jrd_comp_req_s;
endpackage : jrd_pkg

// *** src/jrd_test_selector_eval.sv ***
`timescale 1ns/1ns
// one element's condition test; code TEST_SELECTOR_ALWAYS means "no condition" only
// where the format lets the condition be omitted
module jrd_test_selector_eval
    import jrd_pkg::*;
(
    input  wire logic [4:0]       test_selector,
    input  wire logic [NFLAG-1:0] flags,
    input  wire logic             allow_default,
    output logic                  test_selector_true
);
    // flag vector is already the per-code test result from the element
    always_comb begin
        if (allow_default && test_selector == TEST_SELECTOR_ALWAYS) begin
            test_selector_true = 1'b1;
        end else begin
            test_selector_true = flags[test_selector];
        end
    end
endmodule : jrd_test_selector_eval

// *** dv/jump_return_decode_test.sv ***
`timescale 1ns/1ns
module jump_return_decode_test;
    import jrd_pkg::*;
    logic              ref_clk;
    logic              reset_n;
    logic              instr_valid;
    logic [47:0]       instr;
    logic [AW-1:0]     pc;
    logic              simd_mode;
    logic [NFLAG-1:0]  flags_x;
    logic [NFLAG-1:0]  flags_y;
    logic [AW-1:0]     pc_stack_top;
    logic              status_pushed;
    logic [4:0]        serviced_irq;
    logic              loop_dec_point;
    logic              dag_wr_en;
    logic [4:0]        dag_wr_sel;
    logic [AW-1:0]     dag_wr_data;
    logic              branch_taken_r;
    logic [AW-1:0]     branch_target_r;
    logic              branch_delayed_r;
    logic              pc_stack_pop_r;
    logic              status_stack_pop_r;
    logic [NIRQ-1:0]   latch_clear_r;
    logic [NIRQ-1:0]   mask_ptr_clear_r;
    logic              loop_count_dec_r;
    jrd_dm_req_s       dm_req_r;
    jrd_comp_req_s     comp_req_r;
    int                err_count;
    int                total_checks;
    int                cycles;
    logic [5:0]        rel;

    jrd_decode DUT (.ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr), .pc(pc),
        .simd_mode(simd_mode), .flags_x(flags_x), .flags_y(flags_y), .pc_stack_top(pc_stack_top),
        .status_pushed(status_pushed), .serviced_irq(serviced_irq), .loop_dec_point(loop_dec_point),
        .dag_wr_en(dag_wr_en), .dag_wr_sel(dag_wr_sel), .dag_wr_data(dag_wr_data),
        .branch_taken_r(branch_taken_r), .branch_target_r(branch_target_r), .branch_delayed_r(branch_delayed_r),
        .pc_stack_pop_r(pc_stack_pop_r), .status_stack_pop_r(status_stack_pop_r), .latch_clear_r(latch_clear_r),
        .mask_ptr_clear_r(mask_ptr_clear_r), .loop_count_dec_r(loop_count_dec_r), .dm_req_r(dm_req_r),
        .comp_req_r(comp_req_r));

    // 40 ns core clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard, generous against the roughly 65 cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [47:0] jmp(input logic [2:0] op, input logic dir, input logic [2:0] di,
        input logic [2:0] dm, input logic [4:0] t, input logic [5:0] jf, input logic [3:0] rs, input logic [22:0] c);
        return {op, dir, di, dm, t, jf, rs, c};
    endfunction : jmp

    function automatic logic [47:0] ret(input logic [4:0] sub, input logic [4:0] t, input logic d,
        input logic e, input logic lr, input logic [22:0] c);
        return {OPC_GROUP_ZERO, sub, 2'h0, t, 6'h00, d, e, lr, 1'h0, c};
    endfunction : ret

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // present one instruction; after return the previous one's results are visible
    task automatic send(input logic [47:0] i, input logic [31:0] fx, input logic [31:0] fy);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr       <= i;
        flags_x     <= fx;
        flags_y     <= fy;
        #1;
    endtask : send

    task automatic idle();
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : idle

    task automatic dag_load(input logic [4:0] sel, input logic [23:0] d);
        @(posedge ref_clk);
        dag_wr_en   <= 1'b1;
        dag_wr_sel  <= sel;
        dag_wr_data <= d;
        @(posedge ref_clk);
        dag_wr_en   <= 1'b0;
    endtask : dag_load

    task automatic dec_pulse(input logic exp);
        @(posedge ref_clk);
        loop_dec_point <= 1'b1;
        instr_valid    <= 1'b0;
        @(posedge ref_clk);
        loop_dec_point <= 1'b0;
        #1;
        chk(loop_count_dec_r, exp);
    endtask : dec_pulse

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial begin
        reset_n = 1'b0; instr_valid = 1'b0; instr = '0; pc = '0; simd_mode = 1'b0;
        flags_x = '0; flags_y = '0; pc_stack_top = '0; status_pushed = 1'b0; serviced_irq = '0;
        loop_dec_point = 1'b0; dag_wr_en = 1'b0; dag_wr_sel = '0; dag_wr_data = '0;
        err_count = 0; total_checks = 0; cycles = 0;
        repeat (6) @(posedge ref_clk);
        reset_n      <= 1'b1;
        pc           <= 24'h001000;
        pc_stack_top <= 24'h0abcde;
        // jump index 2 / modify 3, data index 1 / modify 1
        dag_load(5'h12, 24'h000100);
        dag_load(5'h1b, 24'h000010);
        dag_load(5'h01, 24'h000200);
        dag_load(5'h09, 24'h000004);
        // taken indexed jump twice: same target both times, so the index is untouched
        repeat (2) begin
            send(jmp(OPC_JUMP_INDIRECT, 1'b1, 3'h1, 3'h1, 5'h04, 6'h13, 4'h5, 23'h001234), 32'h10, 32'h0);
            idle();
            chk(branch_taken_r, 1'b1);
            chk(branch_target_r, 24'h000110);
            chk(dm_req_r.valid_x, 1'b0);
        end
        // back to back failing jumps; code 1f is a real test here, not "always"
        send(jmp(OPC_JUMP_INDIRECT, 1'b1, 3'h1, 3'h1, TEST_SELECTOR_ALWAYS, 6'h13, 4'h5, 23'h001234), 32'h0, 32'h0);
        send(jmp(OPC_JUMP_INDIRECT, 1'b0, 3'h1, 3'h1, 5'h04, 6'h13, 4'h7, 23'h000000), 32'h0, 32'h0);
        chk(branch_taken_r, 1'b0);
        chk({dm_req_r.valid_x, dm_req_r.write, dm_req_r.reg_sel}, 6'h35);
        chk(dm_req_r.addr_x, 24'h000200);
        chk({comp_req_r.en_x, comp_req_r.op}, {1'b1, 23'h001234});
        idle();
        chk({dm_req_r.valid_x, dm_req_r.write, dm_req_r.reg_sel}, 6'h27);
        chk(dm_req_r.addr_x, 24'h000204);
        chk(comp_req_r.en_x, 1'b0);
        // relative jumps, negative and largest positive offset
        for (int k = 0; k < 2; k++) begin
            rel = (k == 0) ? 6'h3e : 6'h1f;
            send(jmp(OPC_JUMP_RELATIVE, 1'b0, 3'h0, 3'h0, 5'h04, rel, 4'h0, 23'h0), 32'h10, 32'h0);
            idle();
            chk(branch_taken_r, 1'b1);
            chk(branch_target_r, 24'(24'h001000 + {{18{rel[5]}}, rel}));
        end
        // unknown opcode does nothing
        send(48'ha00000000000, 32'hffffffff, 32'hffffffff);
        idle();
        chk({branch_taken_r, pc_stack_pop_r, dm_req_r.valid_x, comp_req_r.en_x}, 4'h0);
        // unconditional subroutine return with plain compute
        send(ret(SUBOP_RET_SUB, TEST_SELECTOR_ALWAYS, 1'b0, 1'b0, 1'b0, 23'h000777), 32'h0, 32'h0);
        idle();
        chk({branch_taken_r, branch_delayed_r}, 2'h2);
        chk(branch_target_r, 24'h0abcde);
        chk({pc_stack_pop_r, status_stack_pop_r}, 2'h2);
        chk({latch_clear_r, mask_ptr_clear_r}, 64'h0);
        chk(comp_req_r.en_x, 1'b1);
        // interrupt returns: delayed, with and without pushed status; reentry bit ignored
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            status_pushed <= (k == 0);
            serviced_irq  <= (k == 0) ? 5'h03 : 5'h1f;
            send(ret(SUBOP_RET_INT, TEST_SELECTOR_ALWAYS, 1'b1, 1'b0, 1'b1, 23'h0), 32'h0, 32'h0);
            idle();
            chk({branch_taken_r, branch_delayed_r, pc_stack_pop_r}, 3'h7);
            chk(status_stack_pop_r, (k == 0));
            chk({latch_clear_r, mask_ptr_clear_r}, (k == 0) ? 64'h0000000800000008 : 64'h8000000080000000);
            dec_pulse(1'b1);
        end
        // reentry return blocks exactly one decrement, point at once or a cycle later
        for (int k = 0; k < 2; k++) begin
            send(ret(SUBOP_RET_SUB, TEST_SELECTOR_ALWAYS, 1'b0, 1'b0, 1'b1, 23'h0), 32'h0, 32'h0);
            if (k == 1) begin
                idle();
            end
            dec_pulse(1'b0);
            dec_pulse(1'b1);
        end
        // else compute: only when the return fails
        for (int k = 0; k < 2; k++) begin
            send(ret(SUBOP_RET_SUB, 5'h05, 1'b0, 1'b1, 1'b0, 23'h000abc), (k == 0) ? 32'h0 : 32'h20, 32'h0);
            idle();
            chk({branch_taken_r, pc_stack_pop_r}, (k == 0) ? 2'h0 : 2'h3);
            chk(comp_req_r.en_x, (k == 0));
        end
        // dual element: returns need both tests, computes follow each element
        @(posedge ref_clk);
        simd_mode <= 1'b1;
        send(ret(SUBOP_RET_SUB, 5'h05, 1'b0, 1'b0, 1'b0, 23'h000111), 32'h20, 32'h0);
        send(ret(SUBOP_RET_SUB, 5'h05, 1'b0, 1'b1, 1'b0, 23'h000111), 32'h20, 32'h0);
        chk(branch_taken_r, 1'b0);
        chk({comp_req_r.en_x, comp_req_r.en_y, comp_req_r.complement_y}, 3'h5);
        send(ret(SUBOP_RET_SUB, 5'h05, 1'b0, 1'b0, 1'b0, 23'h000111), 32'h20, 32'h20);
        chk({comp_req_r.en_x, comp_req_r.en_y}, 2'h1);
        idle();
        chk(branch_taken_r, 1'b1);
        // dual element jump: only the failing element transfers, the secondary at address plus one
        send(jmp(OPC_JUMP_INDIRECT, 1'b0, 3'h1, 3'h1, 5'h04, 6'h13, 4'h2, 23'h0), 32'h0, 32'h10);
        send(jmp(OPC_JUMP_INDIRECT, 1'b0, 3'h1, 3'h1, 5'h04, 6'h13, 4'h2, 23'h0), 32'h10, 32'h0);
        chk({branch_taken_r, dm_req_r.valid_x, dm_req_r.valid_y}, 3'h2);
        chk({dm_req_r.addr_x, dm_req_r.addr_y}, {24'h000208, 24'h000209});
        send(jmp(OPC_JUMP_INDIRECT, 1'b0, 3'h1, 3'h1, 5'h04, 6'h13, 4'h2, 23'h0), 32'h10, 32'h10);
        chk({branch_taken_r, dm_req_r.valid_x, dm_req_r.valid_y}, 3'h1);
        chk(dm_req_r.addr_y, 24'h00020d);
        idle();
        chk({branch_taken_r, dm_req_r.valid_x, dm_req_r.valid_y}, 3'h4);
        summarize();
    end
endmodule : jump_return_decode_test
